// ==== atatf_task_file_status_control.sv ====
// status/control part of a task file behind an axi4-lite slave
// assumes a media engine drives the event inputs and reads cmdStart
`timescale 1ns/1ps
`default_nettype none
`include "atatf_defs.svh"

module atatf_task_file_status_control (
    input wire logic clk_sys, // system clock, 20 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read response valid
    input wire logic s_axi_rready, // read response ready
    input wire logic unitId, // socket strap: this card is unit 1
    input wire logic memMode, // memory-mapped interface mode
    input wire logic opDone, // engine finished current command
    input wire logic opError, // engine reports error at done
    input wire logic writeFault, // fault during write
    input wire logic seekDone, // requested sector located
    input wire logic xferReq, // a word may be moved now
    input wire logic dataFixed, // correctable error corrected
    input wire logic mediaReq, // engine wants a read/write/seek
    output logic mediaGrant, // engine request accepted
    output logic cmdStart, // one-cycle start pulse
    output logic [7:0] cmdCode, // command code being executed
    output logic softReset, // controller soft reset in progress
    output logic host_interrupt_line_n, // interrupt request, active low
    output logic host_interrupt_line_oe // interrupt line output enable
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    atatf_pkg::atatf_state_e state_q;
    atatf_pkg::atatf_status_s status_q;
    logic [7:0] devCtl_q;
    logic [7:0] unitHead_q;
    logic [7:0] cmdCode_q;
    logic [7:0] rstCnt_q;
    logic irqPend_q;
    logic errHold_q;
    logic awHave_q, wHave_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic wrFire, rdFire, stRead;
    logic unitSel, irqEnable;
    logic [7:0] statusByte, driveAddr;

    assign wrFire = awHave_q && wHave_q && !s_axi_bvalid;
    assign rdFire = s_axi_arvalid && s_axi_arready;
    assign stRead = rdFire && (s_axi_araddr == `ATATF_OFF_STATUS);
    assign unitSel = (unitHead_q[`ATATF_DH_UNIT] == unitId);
    assign irqEnable = unitSel && (memMode || !devCtl_q[`ATATF_DC_IDIS]);
    assign statusByte = {status_q[7:2], 1'b0, status_q[0]};
    // bit 7 floats on a real pin; here it reads zero
    assign driveAddr = {1'b0, 1'b1, ~unitHead_q[3:0],
                        ~(unitId && unitSel), ~(!unitId && unitSel)};

    // ----------------------------------------------------------------
    // axi write channel
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ATATF_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awAddr_q)
                    `ATATF_OFF_COMMAND, `ATATF_OFF_DEV_CONTROL,
                    `ATATF_OFF_DRIVE_HEAD: s_axi_bresp <= `ATATF_RESP_OKAY;
                    default: s_axi_bresp <= `ATATF_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !awHave_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !wHave_q && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // ----------------------------------------------------------------
    // axi read channel
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ATATF_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rdFire;
            if (rdFire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `ATATF_RESP_OKAY;
                case (s_axi_araddr)
                    // both status copies show the same byte
                    `ATATF_OFF_STATUS, `ATATF_OFF_ALT_STATUS:
                        s_axi_rdata <= {24'h000000, statusByte};
                    `ATATF_OFF_DRIVE_ADDR: s_axi_rdata <= {24'h000000, driveAddr};
                    `ATATF_OFF_DRIVE_HEAD: s_axi_rdata <= {24'h000000, unitHead_q};
                    `ATATF_OFF_CMD_CODE: s_axi_rdata <= {24'h000000, cmdCode_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `ATATF_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            devCtl_q <= `ATATF_DEVCTL_RST;
            unitHead_q <= `ATATF_DRVHD_RST;
        end else if (wrFire && wStrb_q[0]) begin
            if (awAddr_q == `ATATF_OFF_DEV_CONTROL) begin
                // upper nibble is don't-care; fixed bits forced
                devCtl_q <= {4'h0, 1'b1, wData_q[2:1], 1'b0};
            end
            if (awAddr_q == `ATATF_OFF_DRIVE_HEAD) begin
                unitHead_q <= {1'b1, wData_q[6], 1'b1, wData_q[4:0]};
            end
        end
    end

    // ----------------------------------------------------------------
    // command sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= atatf_pkg::IDLE;
            cmdCode_q <= 8'h00;
            rstCnt_q <= 8'h00;
            cmdStart <= 1'b0;
            softReset <= 1'b0;
        end else begin
            cmdStart <= 1'b0;
            case (state_q)
                atatf_pkg::IDLE: begin
                    if (wrFire && wStrb_q[0] && awAddr_q == `ATATF_OFF_DEV_CONTROL
                        && wData_q[`ATATF_DC_SOFTRST]) begin
                        state_q <= atatf_pkg::SOFT_RST;
                        rstCnt_q <= `ATATF_SOFTRST_CYCLES;
                        softReset <= 1'b1;
                    end else if (wrFire && wStrb_q[0] && awAddr_q == `ATATF_OFF_COMMAND
                                 && unitSel) begin
                        state_q <= atatf_pkg::RUN;
                        cmdCode_q <= wData_q[7:0];
                        cmdStart <= 1'b1;
                    end
                end
                atatf_pkg::RUN: begin
                    if (wrFire && wStrb_q[0] && awAddr_q == `ATATF_OFF_DEV_CONTROL
                        && wData_q[`ATATF_DC_SOFTRST]) begin
                        state_q <= atatf_pkg::SOFT_RST;
                        rstCnt_q <= `ATATF_SOFTRST_CYCLES;
                        softReset <= 1'b1;
                    end else if (opDone) begin
                        state_q <= atatf_pkg::IDLE;
                    end
                end
                atatf_pkg::SOFT_RST: begin
                    // count out the minimum first, then hold reset while the bit stays set
                    if (rstCnt_q != 8'h00) begin
                        rstCnt_q <= rstCnt_q - 8'h01;
                    end else if (!devCtl_q[`ATATF_DC_SOFTRST]) begin
                        state_q <= atatf_pkg::IDLE;
                        softReset <= 1'b0;
                    end
                end
                default: state_q <= atatf_pkg::IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_q <= '0;
            errHold_q <= 1'b0;
        end else begin
            status_q.busy <= (state_q == atatf_pkg::RUN && !opDone)
                          || (state_q == atatf_pkg::IDLE && cmdStart)
                          || state_q == atatf_pkg::SOFT_RST
                          || (wrFire && wStrb_q[0] && awAddr_q == `ATATF_OFF_COMMAND && unitSel);
            status_q.index <= 1'b0;
            if (state_q == atatf_pkg::SOFT_RST) begin
                status_q.wfault <= 1'b0;
                status_q.error <= 1'b0;
                status_q.fixed <= 1'b0;
                status_q.xferReq <= 1'b0;
                errHold_q <= 1'b0;
            end else begin
                status_q.seekDone <= seekDone;
                status_q.xferReq <= xferReq;
                if (writeFault) status_q.wfault <= 1'b1;
                else if (cmdStart) status_q.wfault <= 1'b0;
                if (dataFixed) status_q.fixed <= 1'b1;
                else if (cmdStart) status_q.fixed <= 1'b0;
                if (state_q == atatf_pkg::RUN && opDone && opError) begin
                    status_q.error <= 1'b1;
                    errHold_q <= 1'b1;
                end else if (cmdStart) begin
                    status_q.error <= 1'b0;
                end else if (stRead) begin
                    errHold_q <= 1'b0;
                end
            end
            // ready frozen until the host has seen the error
            if (!errHold_q || stRead) begin
                status_q.ready <= (state_q != atatf_pkg::SOFT_RST);
            end
        end
    end

    // ----------------------------------------------------------------
    // media grant and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mediaGrant <= 1'b0;
        end else begin
            mediaGrant <= mediaReq && status_q.ready && status_q.seekDone;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqPend_q <= 1'b0;
        end else if (state_q == atatf_pkg::RUN && opDone) begin
            irqPend_q <= 1'b1; // completion beats a same-cycle status read
        end else if (stRead || !irqEnable || state_q == atatf_pkg::SOFT_RST) begin
            irqPend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            host_interrupt_line_n <= 1'b1;
            host_interrupt_line_oe <= 1'b0;
        end else begin
            host_interrupt_line_n <= !(irqPend_q && irqEnable && !stRead);
            host_interrupt_line_oe <= irqEnable;
        end
    end

    assign cmdCode = cmdCode_q;

endmodule
`default_nettype wire

// ==== atatf_defs.svh ====
// constants for the task file status and control register bank
// assumes a 32-bit axi4-lite slave with word-aligned registers
`ifndef ATATF_DEFS_SVH
`define ATATF_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ATATF_OFF_STATUS 8'h00
`define ATATF_OFF_ALT_STATUS 8'h04
`define ATATF_OFF_COMMAND 8'h08
`define ATATF_OFF_DEV_CONTROL 8'h0C
`define ATATF_OFF_DRIVE_ADDR 8'h10
`define ATATF_OFF_DRIVE_HEAD 8'h14
`define ATATF_OFF_CMD_CODE 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ATATF_ST_BUSY 7
`define ATATF_ST_READY 6
`define ATATF_ST_WFAULT 5
`define ATATF_ST_SEEKDONE 4
`define ATATF_ST_XFERREQ 3
`define ATATF_ST_FIXED 2
`define ATATF_ST_INDEX 1
`define ATATF_ST_ERROR 0
`define ATATF_DC_SOFTRST 2
`define ATATF_DC_IDIS 1
`define ATATF_DH_UNIT 4

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define ATATF_DEVCTL_RST 8'h08
`define ATATF_DRVHD_RST 8'hA0
`define ATATF_SOFTRST_CYCLES 8'h04
`define ATATF_RESP_OKAY 2'h0
`define ATATF_RESP_SLVERR 2'h2

`endif

// ==== atatf_pkg.sv ====
// types for the task file status and control register bank
// assumes atatf_defs.svh is included by users of numeric fields
`default_nettype none
package atatf_pkg;

    typedef enum logic [1:0] {
        IDLE,
        RUN,
        SOFT_RST
    } atatf_state_e;

    typedef struct packed {
        logic busy;
        logic ready;
        logic wfault;
        logic seekDone;
        logic xferReq;
        logic fixed;
        logic index;
        logic error;
    } atatf_status_s;

endpackage
`default_nettype wire

// ==== atatf_monitor.sv ====
// checker for the status/control bank, bound to the top-level ports
// assumes one clk_sys domain and synchronous active-high rst
`timescale 1ns/1ps
`default_nettype none
module atatf_monitor (
    input wire logic clk_sys, // clock
    input wire logic rst, // reset
    input wire logic [7:0] s_axi_araddr, // read addr
    input wire logic s_axi_arvalid, // read valid
    input wire logic s_axi_arready, // read ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic mediaReq, // engine request
    input wire logic mediaGrant, // engine grant
    input wire logic seekDone, // sector found
    input wire logic cmdStart, // start pulse
    input wire logic opDone, // engine done
    input wire logic softReset, // soft reset
    input wire logic host_interrupt_line_n // irq line
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic runQ;
    logic arTake;
    assign arTake = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge clk_sys) begin
        if (rst || opDone || softReset) begin
            runQ <= 1'b0;
        end else if (cmdStart) begin
            runQ <= 1'b1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    busy_run_a: assert property (
        arTake && s_axi_araddr == 8'h00 && runQ && !opDone |=> s_axi_rdata[7])
        else $error("busy bit low during command");
    irq_clear_a: assert property (
        arTake && s_axi_araddr == 8'h00 && !runQ && !opDone |-> ##[1:3] host_interrupt_line_n)
        else $error("status read left irq asserted");
    alt_keep_a: assert property (
        arTake && s_axi_araddr == 8'h04 && !host_interrupt_line_n && !softReset
        |=> !host_interrupt_line_n) else $error("alternate read dropped irq");
    index_zero_a: assert property (
        arTake && (s_axi_araddr == 8'h00 || s_axi_araddr == 8'h04) |=> !s_axi_rdata[1])
        else $error("index bit read as one");
    grant_req_a: assert property (
        mediaGrant |-> $past(mediaReq)) else $error("grant without request");
    grant_seek_a: assert property (
        !seekDone [*2] |=> !mediaGrant) else $error("grant without seek done");
    softrst_len_a: assert property (
        $rose(softReset) |-> softReset [*4]) else $error("soft reset too short");
    softrst_irq_a: assert property (
        softReset |-> ##[0:2] host_interrupt_line_n) else $error("irq kept in soft reset");
    start_once_a: assert property (
        cmdStart |=> !cmdStart) else $error("start pulse longer than one cycle");
endmodule
bind atatf_task_file_status_control atatf_monitor u_mon (
    .clk_sys, .rst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .mediaReq, .mediaGrant, .seekDone, .cmdStart, .opDone, .softReset,
    .host_interrupt_line_n
);
`default_nettype wire

// ==== atatf_engine_model.sv ====
// media engine stand-in: completes each started command after LAT cycles unless a soft reset drops it
// assumes cmdStart is a one-cycle pulse from the bank
`timescale 1ns/1ps
`default_nettype none
module atatf_engine_model #(
    parameter logic [7:0] LAT = 8'h10
) (
    input wire logic clk_sys, // clock
    input wire logic rst, // reset
    input wire logic cmdStart, // command accepted
    input wire logic softReset, // abandon command
    input wire logic failNext, // end with error
    output logic opDone, // completion pulse
    output logic opError // error with completion
);
    logic [7:0] cnt_q;
    // a soft reset drops the command, but a count at 1 in its first cycle still leaks one opDone
    always_ff @(posedge clk_sys) begin
        if (rst || softReset) begin
            cnt_q <= 8'h00;
        end else if (cmdStart) begin
            cnt_q <= LAT;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    always_ff @(posedge clk_sys) begin
        opDone <= !rst && cnt_q == 8'h01;
        opError <= failNext && cnt_q == 8'h01;
    end
endmodule
`default_nettype wire

// ==== atatf_task_file_status_control_tb.sv ====
// self-checking bench for the status/control bank
// assumes the engine model and bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module atatf_task_file_status_control_tb;
    logic clk_sys = 1'b0, rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, cmdCode;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, unitId = 1'b0, memMode = 1'b0;
    logic writeFault = 1'b0, seekDone = 1'b1, xferReq = 1'b0, dataFixed = 1'b0;
    logic mediaReq = 1'b0, failNext = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic opDone, opError, mediaGrant, cmdStart, softReset;
    logic host_interrupt_line_n, host_interrupt_line_oe;
    logic [7:0] d;
    logic [1:0] r, b;
    int mismatches = 0, compares = 0;
    always #25 clk_sys = ~clk_sys;
    atatf_task_file_status_control u_dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .unitId,
        .memMode, .opDone, .opError, .writeFault, .seekDone, .xferReq, .dataFixed,
        .mediaReq, .mediaGrant, .cmdStart, .cmdCode, .softReset, .host_interrupt_line_n,
        .host_interrupt_line_oe);
    atatf_engine_model u_eng (.clk_sys, .rst, .cmdStart, .softReset, .failNext, .opDone,
        .opError);
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task test_done;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task ranOut;
        mismatches++;
        $display("[ERR] %0t wait ran out", $time);
        test_done;
    endtask
    task automatic axw(input logic [7:0] a, input logic [7:0] v);
        int n = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 100);
        b = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 100) ranOut();
    endtask
    task automatic axr(input logic [7:0] a, output logic [7:0] q, output logic [1:0] p);
        int n = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 100);
        q = s_axi_rdata[7:0];
        p = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 100) ranOut();
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        axr(a, d, r);
        chk(d, e);
    endtask
    // polls the alternate copy so a pending irq survives the wait
    task automatic waitIdle;
        int n = 0;
        d = 8'h80;
        while (d[7] !== 1'b0 && n < 50) begin
            axr(8'h04, d, r);
            n++;
        end
        if (n >= 50) ranOut();
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset;
        // a write to the read-only status must be refused and leave it untouched
        axw(8'h00, 8'hFF);
        chk({6'h00, b}, 8'h02);
        rchk(8'h00, 8'h50);
        rchk(8'h14, 8'hA0);
        axr(8'h1C, d, r);
        chk({6'h00, r}, 8'h02);
        chk(d, 8'h00);
        $display("reset test done");
    endtask
    task t_err;
        failNext <= 1'b1;
        axw(8'h08, 8'h30);
        repeat (2) @(posedge clk_sys);
        {writeFault, dataFixed, xferReq} <= 3'b111;
        @(posedge clk_sys);
        {writeFault, dataFixed} <= 2'b00;
        waitIdle();
        rchk(8'h04, 8'h7D);
        rchk(8'h00, 8'h7D);
        {xferReq, failNext} <= 2'b00;
        repeat (3) @(posedge clk_sys);
        chk({7'h00, host_interrupt_line_n}, 8'h01);
        $display("error test done");
    endtask
    task t_cmd;
        axw(8'h08, 8'h20);
        chk({6'h00, b}, 8'h00);
        chk(cmdCode, 8'h20);
        axr(8'h00, d, r);
        chk(d & 8'h80, 8'h80);
        rchk(8'h18, 8'h20);
        waitIdle();
        repeat (2) @(posedge clk_sys);
        chk({6'h00, host_interrupt_line_oe, host_interrupt_line_n}, 8'h02);
        rchk(8'h04, 8'h50);
        chk({7'h00, host_interrupt_line_n}, 8'h00);
        rchk(8'h00, 8'h50);
        repeat (3) @(posedge clk_sys);
        chk({7'h00, host_interrupt_line_n}, 8'h01);
        $display("command test done");
    endtask
    task automatic t_drv;
        logic [3:0] h;
        for (int i = 0; i < 16; i++) begin
            h = i[3:0];
            axw(8'h14, {4'hA, h});
            rchk(8'h10, {2'b01, ~h, 2'b10});
        end
        axw(8'h14, 8'hB5);
        rchk(8'h10, 8'h6B);
        unitId <= 1'b1;
        rchk(8'h10, 8'h69);
        unitId <= 1'b0;
        axw(8'h08, 8'h20);
        rchk(8'h00, 8'h50);
        chk({7'h00, host_interrupt_line_oe}, 8'h00);
        axw(8'h14, 8'hA0);
        $display("drive address test done");
    endtask
    task t_dis;
        memMode <= 1'b1;
        axw(8'h0C, 8'h0A);
        axw(8'h08, 8'h20);
        waitIdle();
        repeat (2) @(posedge clk_sys);
        chk({6'h00, host_interrupt_line_oe, host_interrupt_line_n}, 8'h02);
        memMode <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk({7'h00, host_interrupt_line_oe}, 8'h00);
        rchk(8'h00, 8'h50);
        axw(8'h0C, 8'h08);
        $display("disable test done");
    endtask
    task t_softrst;
        axw(8'h0C, 8'h0C);
        axr(8'h00, d, r);
        chk(d & 8'hC0, 8'h80);
        // ready is low during soft reset, so a media request must be refused
        mediaReq <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({7'h00, mediaGrant}, 8'h00);
        mediaReq <= 1'b0;
        axw(8'h0C, 8'h08);
        waitIdle();
        rchk(8'h00, 8'h50);
        $display("soft reset test done");
    endtask
    task t_grant;
        mediaReq <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({7'h00, mediaGrant}, 8'h01);
        seekDone <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk({7'h00, mediaGrant}, 8'h00);
        rchk(8'h00, 8'h40);
        {seekDone, mediaReq} <= 2'b10;
        $display("grant test done");
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_err();
        t_cmd();
        t_drv();
        t_dis();
        t_softrst();
        t_grant();
        test_done();
    end
endmodule
`default_nettype wire
